// >>> rtl/imlc_ctrl.sv
// Interrupt mask-level controller with exception stacking engine
`timescale 1ns/10ps

// Functional notes
// - Every source except the non-maskable interrupt and address break sits at one of three mask levels to allow nesting.
// - Levels are set per module, and neither the non-maskable interrupt nor address break is masked by them.
// - Five writable mask-level registers A to E; A to D decide the level of each maskable source and E decides none.
// - An address break raises vector 5 and fetches its handler from H'000A to H'000B.
// - Exception entry pushes the condition code register as a word and return pops it as a word.
// - There are 25 internal sources in the flash variant and 24 otherwise, plus eight wakeup pins.
// - A push is a move to memory at the predecremented stack pointer and a pop a move then postincrement.
// - Each mask-level register holds four 2-bit fields at 7:6, 5:4, 3:2 and 1:0 taking values 0 to 3.
// - The selectable mask levels are 2, 1 and 0.
// - Among pending requests the lower vector wins and order within a module is fixed.
module imlc_ctrl
  import imlc_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     arst_n_i,
  // Mask-level register write port
  input  wire logic                     mlr_wr_i,
  input  wire logic [2:0]               mlr_sel_i,
  input  wire logic [7:0]               mlr_data_i,
  // Interrupt sources
  input  wire logic [NUM_INT_FLASH-1:0] int_req_i,
  input  wire logic [NUM_WKP-1:0]       wkp_pin_i,
  input  wire logic                     nmi_pin_i,
  input  wire logic                     abrk_hit_i,
  // Core side
  input  wire logic [1:0]               core_mask_i,
  input  wire logic                     take_i,
  input  wire logic                     rte_i,
  input  wire logic [15:0]              sp_i,
  input  wire logic [7:0]               ccr_i,
  output logic                          irq_o,
  output logic [5:0]                    irq_vec_o,
  output imlc_core_s                    core_o,
  // Memory port
  output imlc_mem_s                     mem_o,
  input  wire logic [15:0]              mem_rdata_i,
  input  wire logic                     mem_ack_i
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  // Field index of a maskable source: wakeup owns field 0, internal pairs share one
  function automatic int fld_of(input int src);
    fld_of = (src == SRC_WKP) ? 0 : 1 + (src - SRC_INT0) / 2;
  endfunction

  // Value 3 behaves as the top level, so only levels 2, 1, 0 exist
  function automatic logic [1:0] lvl_of(input logic [NUM_REG-1:0][7:0] m, input int src);
    int         f;
    logic [1:0] v;
    f = fld_of(src);
    v = m[f / FLD_PER_REG][(FLD_PER_REG - 1 - f % FLD_PER_REG) * FLD_W +: FLD_W];
    lvl_of = (v == FLD_MAXVAL) ? LVL_TOP : v;
  endfunction

  imlc_state_s s_r;
  imlc_state_s s_nxt;
  logic        found;
  logic [5:0]  win_vec;
  logic        take_ok;
  logic        src_hit;

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  always_comb begin
    s_nxt = s_r;
    found = 1'b0;
    win_vec = 6'h00;
    take_ok = (s_r.st == ST_IDLE) && take_i && s_r.irq;
    src_hit = 1'b0;
    s_nxt.core.sp_we = 1'b0;
    s_nxt.core.ccr_we = 1'b0;
    s_nxt.core.pc_we = 1'b0;
    s_nxt.core.ack = 1'b0;

    // Pins pass three stages; a change counts once stages two and three agree
    s_nxt.wkp_s1 = wkp_pin_i;
    s_nxt.wkp_s2 = s_r.wkp_s1;
    s_nxt.wkp_s3 = s_r.wkp_s2;
    for (int i = 0; i < NUM_WKP; i++) begin
      if (s_r.wkp_s2[i] == s_r.wkp_s3[i]) begin
        s_nxt.wkp_st[i] = s_r.wkp_s3[i];
      end
    end
    s_nxt.nmi_sy = {s_r.nmi_sy[1:0], nmi_pin_i};
    if (s_r.nmi_sy[1] == s_r.nmi_sy[2]) begin
      s_nxt.nmi_st = s_r.nmi_sy[2];
    end

    if (mlr_wr_i && mlr_sel_i <= SEL_LAST) begin
      s_nxt.mlr[mlr_sel_i] = mlr_data_i;
    end

    // Lowest index is lowest vector, so scanning downward leaves the winner
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      src_hit = 1'b0;
      if (i == SRC_ABRK) begin
        src_hit = s_r.abrk_p;
      end else if (i == SRC_NMI) begin
        src_hit = s_r.nmi_p;
      end else if (i == SRC_WKP) begin
        src_hit = (|s_r.wkp_st) && (lvl_of(s_r.mlr, i) >= core_mask_i);
      end else if (FLASH_VARIANT || (i - SRC_INT0) < NUM_INT_OTHER) begin
        src_hit = int_req_i[i - SRC_INT0] && (lvl_of(s_r.mlr, i) >= core_mask_i);
      end
      if (src_hit) begin
        found = 1'b1;
        win_vec = (i == SRC_ABRK) ? VEC_ABRK :
                  (i == SRC_NMI)  ? VEC_NMI  :
                  (i == SRC_WKP)  ? VEC_WKP  : VEC_INT_BASE + 6'(i - SRC_INT0);
      end
    end

    // ******************************************************************
    // Stacking engine
    // ******************************************************************
    case (s_r.st)
      ST_IDLE: begin
        if (take_ok) begin
          s_nxt.cur_vec = s_r.vec;
          if (s_r.vec == VEC_ABRK) begin
            s_nxt.abrk_p = 1'b0;
          end
          if (s_r.vec == VEC_NMI) begin
            s_nxt.nmi_p = 1'b0;
          end
          s_nxt.sp_tmp = sp_i - STK_STEP;
          s_nxt.mem = '{req: 1'b1, we: 1'b1, addr: sp_i - STK_STEP, wdata: {ccr_i, ccr_i}};
          s_nxt.st = ST_PUSH;
        end else if (rte_i) begin
          s_nxt.sp_tmp = sp_i + STK_STEP;
          s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: sp_i, wdata: 16'h0000};
          s_nxt.st = ST_POP;
        end
      end
      ST_PUSH: begin
        if (mem_ack_i) begin
          s_nxt.core.sp = s_r.sp_tmp;
          s_nxt.core.sp_we = 1'b1;
          s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: {9'h000, s_r.cur_vec, 1'b0}, wdata: 16'h0000};
          s_nxt.st = ST_VFETCH;
        end
      end
      ST_VFETCH: begin
        if (mem_ack_i) begin
          s_nxt.core.pc = mem_rdata_i;
          s_nxt.core.pc_we = 1'b1;
          s_nxt.core.ack = 1'b1;
          s_nxt.core.ack_vec = s_r.cur_vec;
          s_nxt.mem.req = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      ST_POP: begin
        if (mem_ack_i) begin
          s_nxt.core.condition_code_register = mem_rdata_i[15:8];
          s_nxt.core.ccr_we = 1'b1;
          s_nxt.core.sp = s_r.sp_tmp;
          s_nxt.core.sp_we = 1'b1;
          s_nxt.mem.req = 1'b0;
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // Sets come after the clears so a new event is never lost
    if (abrk_hit_i) begin
      s_nxt.abrk_p = 1'b1;
    end
    if (s_r.nmi_sy[1] == s_r.nmi_sy[2] && s_r.nmi_sy[2] && !s_r.nmi_st) begin
      s_nxt.nmi_p = 1'b1;
    end

    // Request withdrawn while the engine runs; core samples one vector per entry
    s_nxt.irq = found && (s_r.st == ST_IDLE) && !take_ok;
    s_nxt.vec = win_vec;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '{st: ST_IDLE, mlr: {NUM_REG{MLR_RST}}, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq_o = s_r.irq;
  assign irq_vec_o = s_r.vec;
  assign core_o = s_r.core;
  assign mem_o = s_r.mem;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  AST_MLR_WRITE: assert property (mlr_wr_i && mlr_sel_i <= SEL_LAST |=>
      s_r.mlr[$past(mlr_sel_i)] == $past(mlr_data_i))
    else $error("mask-level register write lost");
  AST_ABRK_FETCH: assert property (s_r.st == ST_PUSH && mem_ack_i && s_r.cur_vec == VEC_ABRK |=>
      mem_o.req && !mem_o.we && mem_o.addr == 16'h000A)
    else $error("address break handler not fetched from H000A");
  AST_PUSH_PREDEC: assert property (take_ok |=> mem_o.req && mem_o.we &&
      mem_o.addr == $past(sp_i) - 16'h0002)
    else $error("push not at predecremented stack pointer");
  AST_CCR_WORD: assert property (take_ok |=> mem_o.wdata == {$past(ccr_i), $past(ccr_i)})
    else $error("condition code not pushed as a word");
  AST_POP_POSTINC: assert property (s_r.st == ST_POP && mem_ack_i |=>
      core_o.sp_we && core_o.sp == $past(mem_o.addr) + 16'h0002 ##1 !core_o.sp_we)
    else $error("pop did not postincrement stack pointer");
  AST_RTE_CCR: assert property (s_r.st == ST_POP && mem_ack_i |=>
      core_o.ccr_we && core_o.condition_code_register == $past(mem_rdata_i[15:8]))
    else $error("condition code not restored from popped word");
  AST_ABRK_WINS: assert property (s_r.abrk_p && s_r.st == ST_IDLE && !take_ok |=>
      irq_o && irq_vec_o == VEC_ABRK)
    else $error("address break did not win arbitration");
  AST_MASK_ALL: assert property (core_mask_i == 2'h3 && !s_r.abrk_p && !s_r.nmi_p |=> !irq_o)
    else $error("masked request reached the core");
  AST_NO_SRC24: assert property (irq_o && irq_vec_o >= VEC_INT_BASE |->
      irq_vec_o < VEC_INT_BASE + 6'(FLASH_VARIANT ? NUM_INT_FLASH : NUM_INT_OTHER))
    else $error("absent internal source raised a request");

endmodule

// >>> rtl/imlc_pkg.sv
// Constants and types for the interrupt mask-level controller
package imlc_pkg;

  // ********************************************************************
  // Source counts and layout
  // ********************************************************************
  localparam int NUM_INT_FLASH = 25;
  localparam int NUM_INT_OTHER = 24;
  localparam int NUM_WKP       = 8;
  localparam int NUM_REG       = 5;
  localparam int FLD_PER_REG   = 4;
  localparam int FLD_W         = 2;
  localparam int SRC_ABRK      = 0;
  localparam int SRC_NMI       = 1;
  localparam int SRC_WKP       = 2;
  localparam int SRC_INT0      = 3;
  localparam int NUM_SRC       = SRC_INT0 + NUM_INT_FLASH;

  // ********************************************************************
  // Vectors, levels, reset values
  // ********************************************************************
  localparam logic [5:0]  VEC_ABRK     = 6'h05;
  localparam logic [5:0]  VEC_NMI      = 6'h07;
  localparam logic [5:0]  VEC_WKP      = 6'h09;
  localparam logic [5:0]  VEC_INT_BASE = 6'h10;
  localparam logic [1:0]  LVL_TOP      = 2'h2;
  localparam logic [1:0]  FLD_MAXVAL   = 2'h3;
  localparam logic [7:0]  MLR_RST      = 8'h00;
  localparam logic [15:0] STK_STEP     = 16'h0002;
  localparam logic [2:0]  SEL_LAST     = 3'h4;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PUSH   = 4'b0010,
    ST_VFETCH = 4'b0100,
    ST_POP    = 4'b1000
  } imlc_st_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } imlc_mem_s;

  typedef struct packed {
    logic [15:0] sp;
    logic        sp_we;
    logic [7:0]  condition_code_register;
    logic        ccr_we;
    logic [15:0] pc;
    logic        pc_we;
    logic        ack;
    logic [5:0]  ack_vec;
  } imlc_core_s;

  typedef struct packed {
    imlc_st_e                   st;
    logic [NUM_REG-1:0][7:0]    mlr;
    logic [NUM_WKP-1:0]         wkp_s1;
    logic [NUM_WKP-1:0]         wkp_s2;
    logic [NUM_WKP-1:0]         wkp_s3;
    logic [NUM_WKP-1:0]         wkp_st;
    logic [2:0]                 nmi_sy;
    logic                       nmi_st;
    logic                       nmi_p;
    logic                       abrk_p;
    logic                       irq;
    logic [5:0]                 vec;
    logic [5:0]                 cur_vec;
    logic [15:0]                sp_tmp;
    imlc_mem_s                  mem;
    imlc_core_s                 core;
  } imlc_state_s;

endpackage

// >>> sim/imlc_core_mdl.sv
// Memory-side model of the core serving the exception engine
`timescale 1ns/10ps
module imlc_core_mdl
  import imlc_pkg::*;
(
  // Clock and pacing
  input  wire logic      clk_sys_i,
  input  wire logic      slow_i,
  // Memory port
  input  wire imlc_mem_s mem_i,
  output logic [15:0]    rdata_o,
  output logic           ack_o
);
  logic [15:0] ram [16];
  logic [1:0]  cnt     = 2'h0;
  logic [15:0] rdata_r = 16'h0000;
  logic        ack_r   = 1'b0;
  initial begin
    for (int i = 0; i < 16; i++) ram[i] = 16'h1000 + 16'(i * 2);
  end
  assign rdata_o = rdata_r;
  assign ack_o   = ack_r;
  // *****************
  // Word-wide store
  // *****************
  always @(posedge clk_sys_i) begin
    if (mem_i.req && !ack_r && cnt == {slow_i, slow_i}) begin
      ack_r <= 1'b1;
      cnt <= 2'h0;
      if (mem_i.we) ram[mem_i.addr[4:1]] <= mem_i.wdata;
      else rdata_r <= ram[mem_i.addr[4:1]];
    end else begin
      ack_r <= 1'b0;
      // Released bus inverts the last word every cycle instead of holding it
      rdata_r <= ~rdata_r;
      if (mem_i.req && !ack_r) cnt <= cnt + 2'h1;
    end
  end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the interrupt mask-level controller
`timescale 1ns/10ps
module tb_top
  import imlc_pkg::*;
;
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] dat;
    logic [4:0] src;
    logic [1:0] msk;
    logic       irq;
    logic [5:0] vec;
  } imlc_row_s;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        mlr_wr_i = 1'b0;
  logic [2:0]  mlr_sel_i = 3'h0;
  logic [7:0]  mlr_data_i = 8'h00;
  logic [24:0] int_req_i = 25'h0;
  logic [7:0]  wkp_pin_i = 8'h00;
  logic        nmi_pin_i = 1'b0;
  logic        abrk_hit_i = 1'b0;
  logic [1:0]  core_mask_i = 2'h0;
  logic        take_i = 1'b0;
  logic        rte_i = 1'b0;
  logic [15:0] sp_i = 16'h0000;
  logic [7:0]  ccr_i = 8'h00;
  logic        slow = 1'b0;
  logic        irq_o;
  logic [5:0]  irq_vec_o;
  logic [15:0] mem_rdata_i;
  logic        mem_ack_i;
  imlc_core_s  core_o;
  imlc_mem_s   mem_o;
  int          bad_count = 0;
  int          compares = 0;
  imlc_row_s   rows [8] = '{
    '{3'h0, 8'h10, 5'h00, 2'h1, 1'b1, 6'h10}, '{3'h0, 8'h10, 5'h00, 2'h2, 1'b0, 6'h00},
    '{3'h0, 8'h30, 5'h00, 2'h2, 1'b1, 6'h10}, '{3'h0, 8'h00, 5'h01, 2'h0, 1'b1, 6'h11},
    '{3'h0, 8'h00, 5'h00, 2'h3, 1'b0, 6'h00}, '{3'h1, 8'h80, 5'h06, 2'h2, 1'b1, 6'h16},
    '{3'h3, 8'h10, 5'h18, 2'h1, 1'b1, 6'h28}, '{3'h5, 8'h00, 5'h06, 2'h2, 1'b1, 6'h16}};

  always #20 clk_sys_i = ~clk_sys_i;

  imlc_ctrl imlc_ctrl_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .mlr_wr_i(mlr_wr_i),
    .mlr_sel_i(mlr_sel_i), .mlr_data_i(mlr_data_i), .int_req_i(int_req_i), .wkp_pin_i(wkp_pin_i),
    .nmi_pin_i(nmi_pin_i), .abrk_hit_i(abrk_hit_i), .core_mask_i(core_mask_i), .take_i(take_i),
    .rte_i(rte_i), .sp_i(sp_i), .ccr_i(ccr_i), .irq_o(irq_o), .irq_vec_o(irq_vec_o),
    .core_o(core_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i));
  imlc_core_mdl imlc_core_mdl_i (.clk_sys_i(clk_sys_i), .slow_i(slow), .mem_i(mem_o),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  // *****************
  // Helpers
  // *****************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk_sys_i);
    mlr_wr_i <= 1'b1;
    mlr_sel_i <= s;
    mlr_data_i <= d;
    @(posedge clk_sys_i);
    mlr_wr_i <= 1'b0;
  endtask
  task automatic till(input bit pop);
    for (int n = 0; n < 40 && (pop ? core_o.ccr_we : core_o.ack) !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    chk("done", pop ? core_o.ccr_we : core_o.ack, 16'h1);
  endtask
  task automatic take_chk(input logic [5:0] v, input logic [15:0] sp, input logic [7:0] cc);
    @(posedge clk_sys_i);
    take_i <= 1'b1;
    sp_i <= sp;
    ccr_i <= cc;
    @(posedge clk_sys_i);
    take_i <= 1'b0;
    #1;
    chk("irq_drop", irq_o, 16'h0);
    chk("push_we", mem_o.we, 16'h1);
    chk("push_addr", mem_o.addr, sp - STK_STEP);
    chk("push_data", mem_o.wdata, {cc, cc});
    till(1'b0);
    chk("handler", core_o.pc, 16'h1000 + {v, 1'b0});
    chk("pc_we", core_o.pc_we, 16'h1);
    chk("ack_vec", core_o.ack_vec, v);
    chk("sp_push", core_o.sp, sp - STK_STEP);
  endtask

  initial begin
    cyc(3000);
    bad_count++;
    print_verdict;
  end

  // *****************
  // Tests
  // *****************
  initial begin
    cyc(2);
    arst_n_i <= 1'b1;
    #1;
    chk("irq_rst", irq_o, 16'h0);
    foreach (rows[k]) begin
      wr(rows[k].sel, rows[k].dat);
      int_req_i <= 25'h1 << rows[k].src;
      core_mask_i <= rows[k].msk;
      cyc(3);
      #1;
      chk("irq", irq_o, rows[k].irq);
      if (rows[k].irq) chk("vec", irq_vec_o, rows[k].vec);
      @(posedge clk_sys_i);
      int_req_i <= 25'h0;
      $display("row %0d done", k);
    end
    wr(3'h0, 8'hF0);
    int_req_i <= 25'h41;
    wkp_pin_i <= 8'h10;
    core_mask_i <= 2'h2;
    cyc(7);
    #1;
    chk("wkp_wins", irq_vec_o, VEC_WKP);
    @(posedge clk_sys_i);
    wkp_pin_i <= 8'h00;
    cyc(7);
    #1;
    chk("low_vec_wins", irq_vec_o, VEC_INT_BASE);
    $display("priority test done");
    @(posedge clk_sys_i);
    int_req_i <= 25'h0;
    core_mask_i <= 2'h3;
    abrk_hit_i <= 1'b1;
    nmi_pin_i <= 1'b1;
    slow <= 1'b1;
    @(posedge clk_sys_i);
    abrk_hit_i <= 1'b0;
    cyc(6);
    #1;
    chk("abrk_irq", irq_o, 16'h1);
    chk("abrk_vec", irq_vec_o, VEC_ABRK);
    take_chk(VEC_ABRK, 16'h0020, 8'hA5);
    cyc(3);
    #1;
    chk("nmi_vec", irq_vec_o, VEC_NMI);
    slow <= 1'b0;
    take_chk(VEC_NMI, 16'h0018, 8'h3C);
    cyc(3);
    #1;
    chk("none_left", irq_o, 16'h0);
    @(posedge clk_sys_i);
    rte_i <= 1'b1;
    sp_i <= 16'h0016;
    @(posedge clk_sys_i);
    rte_i <= 1'b0;
    #1;
    chk("pop_addr", mem_o.addr, 16'h0016);
    till(1'b1);
    chk("ccr_pop", core_o.condition_code_register, 16'h3C);
    chk("sp_pop", core_o.sp, 16'h0018);
    $display("engine test done");
    wr(3'h0, 8'h30);
    int_req_i <= 25'h1;
    core_mask_i <= 2'h1;
    cyc(3);
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    #1;
    chk("rst_irq", irq_o, 16'h0);
    chk("rst_req", mem_o.req, 16'h0);
    cyc(2);
    arst_n_i <= 1'b1;
    cyc(4);
    #1;
    chk("rst_level", irq_o, 16'h0);
    $display("reset test done");
    print_verdict;
  end
endmodule
